// ---- rtl/sfh_defs.vh ----
// Constants shared by the flash host port: register offsets, field positions, reset values
// and counts. Assumes it is included by bare name from the design files under rtl/.
`ifndef SFH_DEFS_VH
`define SFH_DEFS_VH

// ==========================================================================
// Register byte offsets
`define SFH_OFF_EVT 16'h5020
`define SFH_OFF_SRST 16'h5040
`define SFH_OFF_CTRL 16'h5060
`define SFH_OFF_STAT 16'h5064
`define SFH_OFF_TX 16'h5068
`define SFH_OFF_RX 16'h506C
`define SFH_OFF_SEL 16'h5070

// ==========================================================================
// Control register fields
`define SFH_CB_LOOP 0
`define SFH_CB_SPE 1
`define SFH_CB_MASTER 2
`define SFH_CB_CPOL 3
`define SFH_CB_CPHA 4
`define SFH_CB_TXRST 5
`define SFH_CB_RXRST 6
`define SFH_CB_MANSS 7
`define SFH_CB_INHIBIT 8
`define SFH_CB_LSB 9
`define SFH_CTRL_W 10
`define SFH_CTRL_RST 10'h000
`define SFH_CTRL_WMASK 10'h39F

// ==========================================================================
// Status register fields
`define SFH_SB_RXE 0
`define SFH_SB_RXF 1
`define SFH_SB_TXE 2
`define SFH_SB_TXF 3
`define SFH_SB_MODF 4
`define SFH_SB_SLVSEL 5
`define SFH_SB_LOOPERR 9
`define SFH_SB_CMDERR 10
`define SFH_SB_RDERR 11

// ==========================================================================
// Event register fields
`define SFH_EB_MODF 0
`define SFH_EB_SMODF 1
`define SFH_EB_TXE 2
`define SFH_EB_UNDR 3
`define SFH_EB_RXF 4
`define SFH_EB_OVR 5
`define SFH_EB_SSEL 7
`define SFH_EV_MASK 8'hBF
`define SFH_EV_RST 8'h00

// ==========================================================================
// Misc values and counts
`define SFH_SRST_KEY 32'h0000_000A
`define SFH_SRST_CYC 3'h4
`define SFH_SEL_RST 1'b1
`define SFH_SCK_HALF 2'h2
`define SFH_LAST_EDGE 4'hF
`define SFH_NONSTD 1'b0
`define SFH_BYTE_W 8
`define SFH_FIFO_D 32
`define SFH_FIFO_AW 5
`define SFH_CMD_N 4
`define SFH_CMD_LIST 32'h9090_9090
`define SFH_ZERO32 32'h0000_0000

`endif

// ---- rtl/sfh_flash_spi.v ----
// Flash host port: register file, byte-wide SPI shifter, transmit FIFO and event logic.
// Assumes one 125 MHz clock, a synchronous reset and SPI pins resolved by the bench.
`timescale 1ns/1ps
`include "sfh_defs.vh"

// ==========================================================================
// Transmit FIFO
module sfh_fifo #(
   parameter WIDTH = `SFH_BYTE_W,
   parameter DEPTH = `SFH_FIFO_D,
   parameter AW = `SFH_FIFO_AW
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire flush_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   localparam [AW:0] FULL_CNT = DEPTH;
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wp;
   reg [AW-1:0] rp;
   reg [AW:0] cnt;
   wire push;
   wire pop;

   // Handshakes on both sides
   assign in_ready_o = (cnt != FULL_CNT);
   assign out_valid_o = (cnt != {(AW+1){1'b0}});
   assign out_data_o = mem[rp];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // Storage carries no reset, only the pointers and fill count do
   always @(posedge clk_sys_i) begin
      if (push) begin
         mem[wp] <= in_data_i;
      end
   end

   // Pointers and fill count
   always @(posedge clk_sys_i) begin
      if (rst_i || flush_i) begin
         wp <= {AW{1'b0}};
         rp <= {AW{1'b0}};
         cnt <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp <= wp + 1'b1;
         end
         if (pop) begin
            rp <= rp + 1'b1;
         end
         if (push && !pop) begin
            cnt <= cnt + 1'b1;
         end else if (pop && !push) begin
            cnt <= cnt - 1'b1;
         end
      end
   end
endmodule // sfh_fifo

// Functional notes
// - Loopback error flag in non-standard mode only
// - Command error when first byte unsupported
// - Transmit byte loads shifter when enabled
// - Next byte loads as previous completes
// - Last written transmit byte is held
// - Write to full transmit: error response
// - Receive register holds byte after transfer
// - Full receive register: discard, flag overrun
// - Empty receive read flags error; writes ignored
// - Select bit 0, active low, rest reserved
// - Event bits toggle on written ones
// - Mode fault when selected as master
// - Slave fault while selected and disabled
// - Transmit empty event; master does not start when empty
// - Slave underrun strobe, shifts out zeros
// - Receive full strobe per stored byte
// - Receive overrun strobe on full store
// - Slave selected strobe in slave mode
// - Status receive-full tracks unread byte
// - Manual select follows select register
module sfh_flash_spi #(
   parameter [31:0] CMD_LIST = `SFH_CMD_LIST
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire bus_wr_i,
   input wire bus_rd_i,
   input wire [15:0] bus_addr_i,
   input wire [31:0] bus_wdata_i,
   output reg [31:0] bus_rdata_o,
   output reg bus_ack_o,
   output reg bus_err_o,
   input wire sck_i,
   output reg sck_o,
   output reg sck_oe_o,
   input wire ss_n_i,
   output reg ss_n_o,
   output reg ss_n_oe_o,
   input wire io0_i,
   output reg io0_o,
   output reg io0_oe_o,
   input wire io1_i,
   output reg io1_o,
   output reg io1_oe_o
);
   reg [2:0] srst_cnt;
   reg [`SFH_CTRL_W-1:0] ctrl;
   reg sel;
   reg [7:0] ev;
   reg [7:0] rx_data;
   reg rx_full;
   reg rd_err;
   reg modf_st;
   reg cmd_err;
   reg first_pend;
   reg [7:0] tx_last;
   reg [3:0] sync1;
   reg [3:0] sync2;
   reg [1:0] hist;
   reg busy;
   reg done_p;
   reg und_pend;
   reg [1:0] half_cnt;
   reg [3:0] edge_cnt;
   reg [7:0] sh_tx;
   reg [7:0] sh_rx;
   reg bit_q;
   reg [7:0] ev_set;
   wire core_rst;
   wire wr_evt, wr_srst, wr_ctrl, wr_tx, wr_sel, rd_rx, rd_stat;
   wire fifo_ready, fifo_valid;
   wire [7:0] fifo_data;
   wire [7:0] ld_byte;
   wire [7:0] rx_byte;
   wire [`SFH_CMD_N-1:0] cmd_hit;
   wire master, system_enable_bit, cpha, lsb, loop;
   wire ss_s, sck_s, io0_s, io1_s, ss_fall;
   wire s_act, m_ok, m_tick, s_edge, tick, ld, pop, shift_edge, sample_edge, miso;
   wire store_ok, store_ovr;
   wire [31:0] stat_word;

   // ========================================================================
   // Decode and core reset; software reset holds the core for a fixed count
   assign core_rst = rst_i | (srst_cnt != 3'h0);
   assign wr_evt = bus_wr_i && (bus_addr_i == `SFH_OFF_EVT);
   assign wr_srst = bus_wr_i && (bus_addr_i == `SFH_OFF_SRST);
   assign wr_ctrl = bus_wr_i && (bus_addr_i == `SFH_OFF_CTRL);
   assign wr_tx = bus_wr_i && (bus_addr_i == `SFH_OFF_TX) && !core_rst;
   assign wr_sel = bus_wr_i && (bus_addr_i == `SFH_OFF_SEL);
   assign rd_rx = bus_rd_i && (bus_addr_i == `SFH_OFF_RX) && !core_rst;
   assign rd_stat = bus_rd_i && (bus_addr_i == `SFH_OFF_STAT) && !core_rst;
   assign master = ctrl[`SFH_CB_MASTER];
   assign system_enable_bit = ctrl[`SFH_CB_SPE];
   assign cpha = ctrl[`SFH_CB_CPHA];
   assign lsb = ctrl[`SFH_CB_LSB];
   assign loop = ctrl[`SFH_CB_LOOP];

   // Pin inputs after two flops; edges are seen between stage two and the history
   assign ss_s = sync2[0];
   assign sck_s = sync2[1];
   assign io0_s = sync2[2];
   assign io1_s = sync2[3];
   assign ss_fall = hist[0] & ~ss_s;

   // ========================================================================
   // Shifter control, shared by master and slave since only one runs at a time
   assign m_ok = master & system_enable_bit & ~ctrl[`SFH_CB_INHIBIT];
   assign s_act = ~master & system_enable_bit & ~ss_s;
   assign m_tick = busy & master & (half_cnt == `SFH_SCK_HALF - 2'h1);
   assign s_edge = busy & s_act & (sck_s ^ hist[1]);
   assign tick = master ? m_tick : s_edge;
   assign ld = ~busy & (master ? (m_ok & fifo_valid) : s_act);
   assign pop = ld & fifo_valid;
   assign shift_edge = (edge_cnt[0] ^ cpha) & ~(~cpha & (edge_cnt == `SFH_LAST_EDGE));
   // Master samples on the odd edges: its input lags the pin by the synchroniser,
   // so the far side's bit is only settled a full half period after it launched it
   assign sample_edge = master ? edge_cnt[0] : ~(edge_cnt[0] ^ cpha);
   assign miso = loop ? bit_q : (master ? io1_s : io0_s);
   assign store_ok = done_p & ~rx_full;
   assign store_ovr = done_p & rx_full;

   // Bit order reversal for the lsb-first format
   genvar gi;
   generate
      for (gi = 0; gi < `SFH_BYTE_W; gi = gi + 1) begin : g_rev
         assign ld_byte[gi] = lsb ? fifo_data[`SFH_BYTE_W-1-gi] : fifo_data[gi];
         assign rx_byte[gi] = lsb ? sh_rx[`SFH_BYTE_W-1-gi] : sh_rx[gi];
      end
      for (gi = 0; gi < `SFH_CMD_N; gi = gi + 1) begin : g_cmd
         assign cmd_hit[gi] = (fifo_data == CMD_LIST[gi*8 +: 8]);
      end
   endgenerate

   // Status word; loopback error can only rise in a non-standard protocol mode
   assign stat_word = {20'h0_0000, rd_err, cmd_err,
                       loop & `SFH_NONSTD,
                       3'h0, ~s_act, modf_st, ~fifo_ready, ~fifo_valid,
                       rx_full, ~rx_full};

   sfh_fifo #(
      .WIDTH(`SFH_BYTE_W),
      .DEPTH(`SFH_FIFO_D),
      .AW(`SFH_FIFO_AW)
   ) u_tx_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_i(core_rst),
      .flush_i(wr_ctrl & bus_wdata_i[`SFH_CB_TXRST]),
      .in_valid_i(wr_tx),
      .in_ready_o(fifo_ready),
      .in_data_i(bus_wdata_i[7:0]),
      .out_valid_o(fifo_valid),
      .out_ready_i(pop),
      .out_data_o(fifo_data)
   );

   // ========================================================================
   // Bus answer and software reset counter, on the power-on reset only
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         srst_cnt <= 3'h0;
         bus_ack_o <= 1'b0;
         bus_err_o <= 1'b0;
         bus_rdata_o <= `SFH_ZERO32;
      end else begin
         bus_ack_o <= bus_wr_i | bus_rd_i;
         bus_err_o <= (wr_tx & ~fifo_ready)
                      | (wr_srst & (bus_wdata_i != `SFH_SRST_KEY));
         if (srst_cnt != 3'h0) begin
            srst_cnt <= srst_cnt - 3'h1;
         end else if (wr_srst && (bus_wdata_i == `SFH_SRST_KEY)) begin
            srst_cnt <= `SFH_SRST_CYC;
         end
         // Read mux; unmapped and reserved read as zero
         bus_rdata_o <= `SFH_ZERO32;
         if (bus_rd_i) begin
            case (bus_addr_i)
               `SFH_OFF_EVT: bus_rdata_o <= {24'h00_0000, ev};
               `SFH_OFF_CTRL: bus_rdata_o <= {22'h00_0000, ctrl};
               `SFH_OFF_STAT: bus_rdata_o <= stat_word;
               `SFH_OFF_TX: bus_rdata_o <= {24'h00_0000, tx_last};
               `SFH_OFF_RX: bus_rdata_o <= {24'h00_0000, rx_data};
               `SFH_OFF_SEL: bus_rdata_o <= {31'h0000_0000, sel};
               default: bus_rdata_o <= `SFH_ZERO32;
            endcase
         end
      end
   end

   // Synchronisers; stage one feeds stage two only
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         sync1 <= 4'hF;
         sync2 <= 4'hF;
         hist <= 2'h3;
      end else begin
         sync1 <= {io1_i, io0_i, sck_i, ss_n_i};
         sync2 <= sync1;
         hist <= {sck_s, ss_s};
      end
   end

   // Event sources of this cycle
   always @* begin
      ev_set = 8'h00;
      ev_set[`SFH_EB_MODF] = ss_fall & master & ~ss_n_oe_o;
      ev_set[`SFH_EB_SMODF] = ~master & ~system_enable_bit & ~ss_s;
      ev_set[`SFH_EB_TXE] = done_p & ~fifo_valid;
      ev_set[`SFH_EB_UNDR] = done_p & und_pend & ~master;
      ev_set[`SFH_EB_RXF] = store_ok;
      ev_set[`SFH_EB_OVR] = store_ovr;
      ev_set[`SFH_EB_SSEL] = ss_fall & ~master;
   end

   // ========================================================================
   // Core registers
   always @(posedge clk_sys_i) begin
      if (core_rst) begin
         ctrl <= `SFH_CTRL_RST;
         sel <= `SFH_SEL_RST;
         ev <= `SFH_EV_RST;
         rx_data <= 8'h00;
         rx_full <= 1'b0;
         rd_err <= 1'b0;
         modf_st <= 1'b0;
         cmd_err <= 1'b0;
         first_pend <= 1'b1;
         tx_last <= 8'h00;
      end else begin
         if (wr_ctrl) begin
            // The transmit FIFO and receive register reset bits act once and read back as zero
            ctrl <= bus_wdata_i[`SFH_CTRL_W-1:0] & `SFH_CTRL_WMASK;
         end
         if (wr_sel) begin
            sel <= bus_wdata_i[0];
            if (sel && !bus_wdata_i[0]) begin
               first_pend <= 1'b1;
               cmd_err <= 1'b0;
            end
         end
         if (wr_tx && fifo_ready) begin
            tx_last <= bus_wdata_i[7:0];
         end
         if (pop && master && first_pend) begin
            first_pend <= 1'b0;
            cmd_err <= ~(|cmd_hit);
         end
         // Toggle on write, a hardware set in the same cycle wins
         ev <= ((ev ^ (wr_evt ? bus_wdata_i[7:0] : 8'h00)) | ev_set) & `SFH_EV_MASK;
         // Status read clears the mode fault and read error flags unless they rise again now
         modf_st <= (modf_st & ~rd_stat) | ev_set[`SFH_EB_MODF];
         rd_err <= (rd_err & ~rd_stat) | (rd_rx & ~rx_full);
         // Receive register: read empties it, a fresh store refills it
         if ((rd_rx && rx_full) || (wr_ctrl && bus_wdata_i[`SFH_CB_RXRST])) begin
            rx_full <= 1'b0;
         end
         if (store_ok) begin
            rx_data <= rx_byte;
            rx_full <= 1'b1;
         end
      end
   end

   // ========================================================================
   // Shift engine; each byte is sixteen clock edges, numbered from zero
   always @(posedge clk_sys_i) begin
      if (core_rst) begin
         busy <= 1'b0;
         done_p <= 1'b0;
         und_pend <= 1'b0;
         half_cnt <= 2'h0;
         edge_cnt <= 4'h0;
         sh_tx <= 8'h00;
         sh_rx <= 8'h00;
         bit_q <= 1'b0;
      end else begin
         done_p <= 1'b0;
         if (ld) begin
            // a waiting byte loads in the cycle the previous one is stored
            busy <= 1'b1;
            half_cnt <= 2'h0;
            edge_cnt <= 4'h0;
            und_pend <= ~fifo_valid;
            if (cpha) begin
               sh_tx <= fifo_valid ? ld_byte : 8'h00;
            end else begin
               bit_q <= fifo_valid ? ld_byte[7] : 1'b0;
               sh_tx <= fifo_valid ? {ld_byte[6:0], 1'b0} : 8'h00;
            end
         end else if (busy && !master && !s_act) begin
            // Slave deselected mid-byte: the partial byte is dropped
            busy <= 1'b0;
         end else if (busy) begin
            half_cnt <= m_tick ? 2'h0 : half_cnt + 2'h1;
            if (tick) begin
               edge_cnt <= edge_cnt + 4'h1;
               if (shift_edge) begin
                  bit_q <= sh_tx[7];
                  sh_tx <= {sh_tx[6:0], 1'b0};
               end
               // Exactly eight samples per byte
               if (sample_edge) begin
                  sh_rx <= {sh_rx[6:0], miso};
               end
               if (edge_cnt == `SFH_LAST_EDGE) begin
                  busy <= 1'b0;
                  done_p <= 1'b1;
               end
            end
         end
      end
   end

   // ========================================================================
   // Pin drivers, all registered; a disabled system leaves every pin undriven
   always @(posedge clk_sys_i) begin
      if (core_rst) begin
         sck_o <= 1'b0;
         sck_oe_o <= 1'b0;
         ss_n_o <= 1'b1;
         ss_n_oe_o <= 1'b0;
         io0_o <= 1'b0;
         io0_oe_o <= 1'b0;
         io1_o <= 1'b0;
         io1_oe_o <= 1'b0;
      end else begin
         sck_oe_o <= master & system_enable_bit;
         ss_n_oe_o <= master & system_enable_bit;
         io0_oe_o <= master & system_enable_bit;
         io1_oe_o <= s_act;
         io0_o <= bit_q;
         io1_o <= bit_q;
         if (!busy) begin
            sck_o <= ctrl[`SFH_CB_CPOL];
         end else if (m_tick) begin
            sck_o <= ~sck_o;
         end
         if (ctrl[`SFH_CB_MANSS] && master && system_enable_bit) begin
            ss_n_o <= sel;
         end else begin
            ss_n_o <= ~(busy | ld);
         end
      end
   end
endmodule // sfh_flash_spi

// ---- testbench/sfh_chk.sv ----
// Checker for the flash host port: bus answers, reserved bits and SPI pin relations.
// Assumes it is bound to sfh_flash_spi and sees only that module's ports.
`timescale 1ns/1ps
`include "sfh_defs.vh"

// ====================
// Checker
module sfh_chk (
   input wire clk_sys_i,
   input wire rst_i,
   input wire bus_wr_i,
   input wire bus_rd_i,
   input wire [15:0] bus_addr_i,
   input wire [31:0] bus_rdata_o,
   input wire bus_ack_o,
   input wire bus_err_o,
   input wire sck_o,
   input wire sck_oe_o,
   input wire ss_n_oe_o,
   input wire io0_oe_o
);
   // One domain, so clock and reset are stated once
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   ack_after_req_a: assert property ((bus_wr_i || bus_rd_i) |=> bus_ack_o)
      else $error("no answer one cycle after a request");
   err_with_ack_a: assert property (bus_err_o |-> bus_ack_o)
      else $error("error response without an answer strobe");
   rx_write_ok_a: assert property ((bus_wr_i && bus_addr_i == `SFH_OFF_RX) |=> !bus_err_o)
      else $error("write to receive register refused");
   rx_byte_only_a: assert property ((bus_rd_i && bus_addr_i == `SFH_OFF_RX)
      |=> bus_rdata_o[31:8] == 24'h00_0000)
      else $error("receive register upper bits not zero");
   sel_one_bit_a: assert property ((bus_rd_i && bus_addr_i == `SFH_OFF_SEL)
      |=> bus_rdata_o[31:1] == 31'h0000_0000)
      else $error("select register reserved bits set");
   evt_reserved_a: assert property ((bus_rd_i && bus_addr_i == `SFH_OFF_EVT)
      |=> bus_rdata_o[31:8] == 24'h00_0000 && !bus_rdata_o[6])
      else $error("event register reserved bits set");
   loop_err_low_a: assert property ((bus_rd_i && bus_addr_i == `SFH_OFF_STAT)
      |=> !bus_rdata_o[9] && (bus_rdata_o[0] != bus_rdata_o[1]))
      else $error("loopback error or receive full/empty flags wrong");
   sck_half_a: assert property ($rose(sck_o) |=> sck_o ##1 !sck_o)
      else $error("serial clock half period not two clocks");
   master_pins_a: assert property (ss_n_oe_o |-> sck_oe_o && io0_oe_o)
      else $error("master pins not driven together");
endmodule // sfh_chk

bind sfh_flash_spi sfh_chk u_sfh_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_addr_i(bus_addr_i),
   .bus_rdata_o(bus_rdata_o), .bus_ack_o(bus_ack_o), .bus_err_o(bus_err_o),
   .sck_o(sck_o), .sck_oe_o(sck_oe_o), .ss_n_oe_o(ss_n_oe_o), .io0_oe_o(io0_oe_o));

// ---- testbench/sfh_flash_model.sv ----
// Behavioural serial flash: mode 0, answers the identification command only.
// Assumes resolved select, clock and data lines from the bench.
`timescale 1ns/1ps

// ====================
// Flash model
module sfh_flash_model #(
   parameter [7:0] MAKER_ID = 8'hA5, // Arbitrary value
   parameter [7:0] PART_ID = 8'h3C // Arbitrary value
) (
   input wire clk_sys_i,
   input wire sck_i,
   input wire ss_n_i,
   input wire mosi_i,
   output wire miso_o
);
   reg [7:0] opcode = 8'h00;
   reg [15:0] out_sr = 16'h0000;
   reg talk = 1'b0;
   reg junk = 1'b0;
   integer nbits = 0;
   // Released line shows a changing pattern, so stale bits never pass
   always @(posedge clk_sys_i) junk <= ~junk;
   assign miso_o = talk ? out_sr[15] : junk;
   // Each selection starts a new command
   always @(ss_n_i) begin
      nbits = 0;
      talk = 1'b0;
   end
   // Sample on the rising clock, first byte is the opcode
   always @(posedge sck_i) if (!ss_n_i) begin
      if (nbits < 8) opcode = {opcode[6:0], mosi_i};
      nbits = nbits + 1;
   end
   // Shift on the falling clock; codes follow opcode and three address bytes
   always @(negedge sck_i) if (!ss_n_i) begin
      if (talk) out_sr = {out_sr[14:0], junk};
      else if (nbits == 32 && opcode == 8'h90) begin
         out_sr = {MAKER_ID, PART_ID};
         talk = 1'b1;
      end
   end
endmodule // sfh_flash_model

// ---- testbench/sfh_flash_spi_bench.sv ----
// Self-checking bench for the flash host port: register tasks, flash model, slave frames.
// Assumes sfh_defs.vh on the include path and the checker bound to the design.
`timescale 1ns/1ps
`include "sfh_defs.vh"

// ====================
// Bench
module sfh_flash_spi_bench;
   localparam [7:0] MAKER_ID = 8'h5A; // Arbitrary value
   localparam [7:0] PART_ID = 8'hC6; // Arbitrary value
   reg clk_sys_i, rst_i, bus_wr_i, bus_rd_i, ext_sck, ext_ss_n, ext_mosi;
   reg [15:0] bus_addr_i;
   reg [31:0] bus_wdata_i, rd_val;
   wire [31:0] bus_rdata_o;
   wire bus_ack_o, bus_err_o, sck_o, sck_oe_o, ss_n_o, ss_n_oe_o;
   wire io0_o, io0_oe_o, io1_o, io1_oe_o, flash_miso;
   integer n_errors, samples_checked, cycles, i;
   // Pins resolved from the port's output enables
   wire sck_line = sck_oe_o ? sck_o : ext_sck;
   wire ss_line = ss_n_oe_o ? ss_n_o : ext_ss_n;
   wire mosi_line = io0_oe_o ? io0_o : ext_mosi;
   wire miso_line = io1_oe_o ? io1_o : flash_miso;

   sfh_flash_spi u_sfh_flash_spi (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_addr_i(bus_addr_i),
      .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .bus_ack_o(bus_ack_o),
      .bus_err_o(bus_err_o), .sck_i(sck_line), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
      .ss_n_i(ss_line), .ss_n_o(ss_n_o), .ss_n_oe_o(ss_n_oe_o), .io0_i(mosi_line),
      .io0_o(io0_o), .io0_oe_o(io0_oe_o), .io1_i(miso_line), .io1_o(io1_o),
      .io1_oe_o(io1_oe_o));
   sfh_flash_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) u_sfh_flash_model (
      .clk_sys_i(clk_sys_i), .sck_i(sck_line), .ss_n_i(ss_line), .mosi_i(mosi_line),
      .miso_o(flash_miso));

   // Clock
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   task chk(input [8*12:1] what, input [31:0] exp, input [31:0] got);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   // One-cycle request; the answer lands on the next edge
   task wr(input [15:0] a, input [31:0] d, input e);
      begin
         @(posedge clk_sys_i);
         bus_wr_i <= 1'b1;
         bus_addr_i <= a;
         bus_wdata_i <= d;
         @(posedge clk_sys_i);
         bus_wr_i <= 1'b0;
         #1 chk("write err", {31'h0000_0000, e}, {31'h0000_0000, bus_err_o});
      end
   endtask
   task rd(input [15:0] a);
      begin
         @(posedge clk_sys_i);
         bus_rd_i <= 1'b1;
         bus_addr_i <= a;
         @(posedge clk_sys_i);
         bus_rd_i <= 1'b0;
         #1 rd_val = bus_rdata_o;
      end
   endtask
   task rdc(input [15:0] a, input [31:0] m, input [31:0] exp, input [8*12:1] what);
      begin
         rd(a);
         chk(what, exp, rd_val & m);
      end
   endtask
   // Bounded wait until all bits of m read as set
   task poll(input [15:0] a, input [31:0] m);
      integer k;
      begin
         k = 0;
         rd(a);
         while ((rd_val & m) !== m && k < 1000) begin
            rd(a);
            k = k + 1;
         end
         chk("poll", m, rd_val & m);
      end
   endtask
   // Check events, toggle them back, expect all clear
   task evt_clear(input [31:0] exp);
      begin
         rdc(`SFH_OFF_EVT, 32'hFFFF_FFFF, exp, "events");
         wr(`SFH_OFF_EVT, exp, 1'b0);
         rdc(`SFH_OFF_EVT, 32'hFFFF_FFFF, 32'h0000_0000, "events clr");
      end
   endtask
   task ss_pulse;
      begin
         ext_ss_n = 1'b0;
         #200 ext_ss_n = 1'b1;
         #200;
      end
   endtask
   // External master frame; link clock runs only inside it, 64 ns period
   task slave_byte(input [7:0] b);
      integer k;
      begin
         ext_ss_n = 1'b0;
         #100;
         for (k = 7; k >= 0; k = k - 1) begin
            ext_mosi = b[k];
            #32 ext_sck = 1'b1;
            #4 chk("slave out", 32'h0000_0002, {30'h0, io1_oe_o, io1_o});
            #28 ext_sck = 1'b0;
         end
         #100 ext_ss_n = 1'b1;
         #200;
      end
   endtask
   task end_test(input [8*16:1] name);
      $display("test %0s done, mismatches %0d", name, n_errors);
   endtask
   task final_report;
      begin
         $display("checked %0d mismatches %0d", samples_checked, n_errors);
         if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   // Hang guard, well above the few thousand cycles the tests need
   initial cycles = 0;
   always @(posedge clk_sys_i) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         final_report;
      end
   end

   // ====================
   // Tests
   initial begin
      n_errors = 0;
      samples_checked = 0;
      rst_i = 1'b1;
      {bus_wr_i, bus_rd_i, ext_sck, ext_mosi} = 4'h0;
      ext_ss_n = 1'b1;
      bus_addr_i = 16'h0000;
      bus_wdata_i = 32'h0000_0000;
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rdc(`SFH_OFF_EVT, 32'hFFFF_FFFF, 32'h0000_0000, "evt reset");
      rdc(`SFH_OFF_SEL, 32'hFFFF_FFFF, 32'h0000_0001, "sel reset");
      rdc(`SFH_OFF_STAT, 32'h0000_0E07, 32'h0000_0005, "stat reset");
      rdc(16'h5030, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
      rd(`SFH_OFF_RX);
      rdc(`SFH_OFF_STAT, 32'h0000_0800, 32'h0000_0800, "empty rd err");
      wr(`SFH_OFF_RX, 32'h0000_0055, 1'b0);
      rdc(`SFH_OFF_STAT, 32'h0000_0003, 32'h0000_0001, "rx unchanged");
      wr(`SFH_OFF_SRST, 32'h0000_0005, 1'b1);
      wr(`SFH_OFF_SRST, `SFH_SRST_KEY, 1'b0);
      repeat (5) @(posedge clk_sys_i);
      wr(`SFH_OFF_CTRL, 32'h0000_00E6, 1'b0);
      rdc(`SFH_OFF_CTRL, 32'h0000_03FF, 32'h0000_0086, "control");
      end_test("reset config");
      wr(`SFH_OFF_SEL, 32'h0000_0000, 1'b0);
      for (i = 0; i < 6; i = i + 1) begin
         wr(`SFH_OFF_TX, (i == 0) ? 32'h0000_0090 : 32'h0000_0000, 1'b0);
         poll(`SFH_OFF_STAT, 32'h0000_0002);
         rd(`SFH_OFF_RX);
         if (i > 3) chk("id byte", {24'h00_0000, (i == 4) ? MAKER_ID : PART_ID}, rd_val);
         if (i == 0) evt_clear(32'h0000_0014);
      end
      chk("select pin", 32'h0000_0000, {31'h0000_0000, ss_n_o});
      rdc(`SFH_OFF_STAT, 32'h0000_0603, 32'h0000_0001, "cmd ok");
      wr(`SFH_OFF_SEL, 32'h0000_0001, 1'b0);
      evt_clear(32'h0000_0014);
      end_test("id read");
      wr(`SFH_OFF_CTRL, 32'h0000_00E7, 1'b0);
      wr(`SFH_OFF_SEL, 32'h0000_0000, 1'b0);
      wr(`SFH_OFF_TX, 32'h0000_00A5, 1'b0);
      wr(`SFH_OFF_TX, 32'h0000_003C, 1'b0);
      wr(`SFH_OFF_TX, 32'h0000_0011, 1'b0);
      poll(`SFH_OFF_EVT, 32'h0000_0024);
      rdc(`SFH_OFF_RX, 32'h0000_00FF, 32'h0000_00A5, "kept byte");
      rdc(`SFH_OFF_STAT, 32'h0000_0600, 32'h0000_0400, "cmd err");
      evt_clear(32'h0000_0034);
      wr(`SFH_OFF_SEL, 32'h0000_0001, 1'b0);
      end_test("loop overrun");
      wr(`SFH_OFF_CTRL, 32'h0000_0186, 1'b0);
      for (i = 0; i < 33; i = i + 1)
         wr(`SFH_OFF_TX, i, (i == 32));
      rdc(`SFH_OFF_STAT, 32'h0000_000C, 32'h0000_0008, "tx full");
      wr(`SFH_OFF_CTRL, 32'h0000_0086, 1'b0);
      poll(`SFH_OFF_EVT, 32'h0000_0004);
      rdc(`SFH_OFF_STAT, 32'h0000_000C, 32'h0000_0004, "tx drained");
      end_test("fifo fill");
      wr(`SFH_OFF_SRST, `SFH_SRST_KEY, 1'b0);
      repeat (5) @(posedge clk_sys_i);
      ss_pulse;
      evt_clear(32'h0000_0082);
      wr(`SFH_OFF_CTRL, 32'h0000_0004, 1'b0);
      ss_pulse;
      evt_clear(32'h0000_0001);
      wr(`SFH_OFF_CTRL, 32'h0000_0002, 1'b0);
      slave_byte(8'hC3);
      evt_clear(32'h0000_009C);
      rdc(`SFH_OFF_RX, 32'h0000_00FF, 32'h0000_00C3, "slave rx");
      end_test("slave events");
      final_report;
   end
endmodule // sfh_flash_spi_bench
